/* rcs_map.svh */
`ifndef RCS_MAP_SVH
`define RCS_MAP_SVH

// Clock rates and derived reference timing
`define RCS_CLK_MHZ 250
`define RCS_REF_MHZ 25
`define RCS_REF_PERIOD_CYC (`RCS_CLK_MHZ / `RCS_REF_MHZ)
`define RCS_REF_HALF_CYC (`RCS_REF_PERIOD_CYC / 2)
`define RCS_SSC_EXTRA_CYC 1
`define RCS_LOCK_EDGES 32
`define RCS_MISS_CYC (4 * `RCS_REF_PERIOD_CYC)

// Register indices; byte address is four times the index
`define RCS_IDX_CFG 16'h0003
`define RCS_IDX_XTAL 16'h0004
`define RCS_IDX_OUT 16'h0006
`define RCS_IDX_CLKMODE 16'h0007
`define RCS_IDX_LINKSTAT 16'h0008
`define RCS_IDX_STATUS 16'h14AA

// Field positions
`define RCS_CFG_ROUTE_BIT 2
`define RCS_XTAL_ON_BIT 0
`define RCS_OUT_EN_BIT 5
`define RCS_STAT_REV_BIT 5
`define RCS_MODE_DPLL_BIT 2
`define RCS_MODE_MULT_LSB 8
`define RCS_LS_STRAP_XTAL_BIT 1
`define RCS_LS_STRAP_BAD_BIT 2
`define RCS_LS_PERIOD_LSB 8

// Synthesiser: output = reference * mult / 64
`define RCS_MULT_RST 8'h40
`define RCS_MULT_MIN 8'h03
`define RCS_MULT_MAX 8'hC0
`define RCS_THR_LOCKED 16'h0040
`define RCS_THR_SLOW 16'h0047

// Strap bands in tenths of a percent of the I/O supply
`define RCS_B0_HI 10'h075
`define RCS_B1_LO 10'h0A9
`define RCS_B1_HI 10'h0EC
`define RCS_B2_LO 10'h120
`define RCS_B2_HI 10'h163
`define RCS_B3_LO 10'h197
`define RCS_B3_HI 10'h1DA
`define RCS_B4_LO 10'h20E
`define RCS_B4_HI 10'h251
`define RCS_B5_LO 10'h285
`define RCS_B5_HI 10'h2C8
`define RCS_B6_LO 10'h2FC
`define RCS_B6_HI 10'h33F
`define RCS_ADDR_LOW 8'h80
`define RCS_ADDR_HIGH 8'h84

`endif

/* rcs_pkg.sv */
package rcs_pkg;

   typedef enum logic [2:0] {
      RCS_LK_DOWN = 3'b001,
      RCS_LK_ACQ = 3'b010,
      RCS_LK_LOCK = 3'b100
   } rcs_lock_t;

   typedef enum logic [1:0] {
      RCS_DIV_1 = 2'h0,
      RCS_DIV_2 = 2'h1,
      RCS_DIV_4 = 2'h2,
      RCS_DIV_4B = 2'h3
   } rcs_div_t;

endpackage

/* rcs_link_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface rcs_link_if;
   logic rev_ref;
   logic ref_request;
   logic link_locked;

   modport dev (
      input rev_ref,
      output ref_request,
      output link_locked
   );

   modport deser (
      output rev_ref,
      input ref_request,
      input link_locked
   );
endinterface

`default_nettype wire

/* rcs_deser.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rcs_map.svh"

module rcs_deser (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // User side
   input wire logic ssc_enable,
   output logic ref_sending,
   output logic link_up,
   // Link
   rcs_link_if.deser lnk
);

   logic [2:0] half_cnt;
   logic [7:0] mod_cnt;
   logic stretch;
   logic [2:0] half_len;

   // Spreading is applied here only; the far end just follows
   always_comb begin
      if (mod_cnt[7]) begin
         stretch = ssc_enable & (mod_cnt[1:0] == 2'h0);
      end else begin
         stretch = ssc_enable & (mod_cnt[2:0] == 3'h0);
      end
      half_len = 3'(`RCS_REF_HALF_CYC) +
         (stretch ? 3'(`RCS_SSC_EXTRA_CYC) : 3'h0);
   end

   // Reference is sent as soon as the far end asks, no setup needed
   always_ff @(posedge clock) begin
      if (!rstn) begin
         lnk.rev_ref <= 1'b0;
         half_cnt <= 3'h0;
         mod_cnt <= 8'h00;
      end else if (!lnk.ref_request) begin
         lnk.rev_ref <= 1'b0;
         half_cnt <= 3'h0;
      end else if (half_cnt == half_len - 3'h1) begin
         lnk.rev_ref <= ~lnk.rev_ref;
         half_cnt <= 3'h0;
         mod_cnt <= mod_cnt + 8'h01;
      end else begin
         half_cnt <= half_cnt + 3'h1;
      end
   end

   // One instance per link, so mixed modes coexist freely
   always_ff @(posedge clock) begin
      if (!rstn) begin
         ref_sending <= 1'b0;
         link_up <= 1'b0;
      end else begin
         ref_sending <= lnk.ref_request;
         link_up <= lnk.link_locked;
      end
   end

endmodule

`default_nettype wire

/* rcs_device.sv */
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rcs_map.svh"

// Overview of operation
// - Run only from crystal or link reference
// - Reverse mode takes reference from link
// - Divider mode outputs reference /1, /2, /4
// - Synthesiser mode programs 1 to 75 MHz
// - Sensor clock disabled after reset
// - Output frequency tracks reference in ratio
// - Output on primary or alternate pin
// - Strap low bands pick source and address
// - Strap high bands pick source and address
// - Deserializer sends reference without configuration
// - Multi-link deserializer allows mixed modes
// - Status bit shows reverse reference locked
// - Clearing crystal bit relocks on link reference
// - Setting crystal bit relocks on crystal
// - Crystal pins disabled in reverse mode
// - Spreading enabled at deserializer only
// - Output follows modulated link reference
// - Feed sensor from this output
// - Output enable bit starts sensor clock
// - Route bit: low primary, high alternate
// - Unlocked reverse mode runs ten percent slow

module rcs_device #(
   parameter int LOCK_EDGES = `RCS_LOCK_EDGES,
   parameter int MISS_CYC = `RCS_MISS_CYC
) (
   // Clock, reset and power-down
   input wire logic clock,
   input wire logic rstn,
   input wire logic pwdn_n,
   // APB register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Strap and identity
   input wire logic [9:0] config_strap_input,
   output logic [7:0] device_address,
   // Crystal pins
   input wire logic crystal_in_pin,
   output logic crystal_in_pin_en,
   output logic crystal_out_pin_o,
   output logic crystal_out_pin_oe,
   // Sensor clock pins
   output logic multi_func_pin_primary_o,
   output logic multi_func_pin_primary_oe,
   output logic multi_func_pin_alternate_o,
   output logic multi_func_pin_alternate_oe,
   // Link
   rcs_link_if.dev lnk
);

   logic strap_done;
   logic strap_crystal;
   logic strap_bad;
   logic [2:0] strap_dec;
   logic crystal_driver_on;
   logic route_alt;
   logic out_en;
   rcs_pkg::rcs_div_t div_sel;
   logic dpll_mode;
   logic [7:0] mult;
   logic [7:0] mult_w;
   logic access;
   logic wr_en;
   logic [15:0] idx;
   logic hit;
   logic [31:0] rd_data;
   logic ref_raw;
   logic ref_q;
   logic ref_q2;
   logic ref_rise;
   logic [7:0] ph_cnt;
   logic [7:0] period;
   logic ref_lost;
   logic xtal_prev;
   logic src_change;
   rcs_pkg::rcs_lock_t lock_state;
   logic [5:0] edge_cnt;
   logic reverse_ref_detected;
   logic [8:0] step_sel;
   logic [8:0] step_cur;
   logic slow;
   logic [15:0] thr;
   logic [16:0] acc_sum;
   logic [15:0] acc;
   logic sclk;

   // Band gaps and the top band fall back to crystal, low address
   function automatic logic [2:0] strap_decode(input logic [9:0] v);
      logic [2:0] r;
      r = 3'b110;
      if (v <= `RCS_B0_HI) r = 3'b000;
      else if (v >= `RCS_B1_LO && v <= `RCS_B1_HI) r = 3'b001;
      else if (v >= `RCS_B2_LO && v <= `RCS_B2_HI) r = 3'b010;
      else if (v >= `RCS_B3_LO && v <= `RCS_B3_HI) r = 3'b001;
      else if (v >= `RCS_B4_LO && v <= `RCS_B4_HI) r = 3'b000;
      else if (v >= `RCS_B5_LO && v <= `RCS_B5_HI) r = 3'b011;
      else if (v >= `RCS_B6_LO && v <= `RCS_B6_HI) r = 3'b010;
      return r;
   endfunction

   assign strap_dec = strap_decode(config_strap_input);

   always_ff @(posedge clock) begin
      if (!rstn) begin
         strap_done <= 1'b0;
         strap_crystal <= 1'b1;
         strap_bad <= 1'b0;
         device_address <= `RCS_ADDR_LOW;
      end else if (!pwdn_n) begin
         strap_done <= 1'b0;
      end else if (!strap_done) begin
         strap_done <= 1'b1;
         strap_bad <= strap_dec[2];
         strap_crystal <= strap_dec[1];
         device_address <= strap_dec[0] ? `RCS_ADDR_HIGH : `RCS_ADDR_LOW;
      end
   end

   // APB slave, zero wait states: answer in the first access cycle
   assign access = psel & penable & pready;
   assign wr_en = access & pwrite;
   assign idx = {2'b00, paddr[15:2]};

   always_comb begin
      hit = 1'b1;
      rd_data = 32'h0000_0000;
      unique case (idx)
         `RCS_IDX_CFG: rd_data[`RCS_CFG_ROUTE_BIT] = route_alt;
         `RCS_IDX_XTAL: rd_data[`RCS_XTAL_ON_BIT] = crystal_driver_on;
         `RCS_IDX_OUT: rd_data[`RCS_OUT_EN_BIT] = out_en;
         `RCS_IDX_CLKMODE: begin
            rd_data[1:0] = div_sel;
            rd_data[`RCS_MODE_DPLL_BIT] = dpll_mode;
            rd_data[`RCS_MODE_MULT_LSB +: 8] = mult;
         end
         `RCS_IDX_LINKSTAT: begin
            rd_data[0] = (lock_state == rcs_pkg::RCS_LK_LOCK);
            rd_data[`RCS_LS_STRAP_XTAL_BIT] = strap_crystal;
            rd_data[`RCS_LS_STRAP_BAD_BIT] = strap_bad;
            rd_data[`RCS_LS_PERIOD_LSB +: 8] = period;
         end
         `RCS_IDX_STATUS: rd_data[`RCS_STAT_REV_BIT] = reverse_ref_detected;
         default: hit = 1'b0;
      endcase
      if (paddr[1:0] != 2'b00) begin
         hit = 1'b0;
         rd_data = 32'h0000_0000;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit;
         prdata <= (psel & ~penable & ~pwrite) ? rd_data : 32'h0000_0000;
      end
   end

   // Synthesiser range clamped to 1..75 MHz
   always_comb begin
      mult_w = pwdata[`RCS_MODE_MULT_LSB +: 8];
      if (mult_w < `RCS_MULT_MIN) mult_w = `RCS_MULT_MIN;
      else if (mult_w > `RCS_MULT_MAX) mult_w = `RCS_MULT_MAX;
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         route_alt <= 1'b0;
         out_en <= 1'b0;
         div_sel <= rcs_pkg::RCS_DIV_1;
         dpll_mode <= 1'b0;
         mult <= `RCS_MULT_RST;
      end else if (wr_en && paddr[1:0] == 2'b00) begin
         if (idx == `RCS_IDX_CFG) begin
            route_alt <= pwdata[`RCS_CFG_ROUTE_BIT];
         end
         if (idx == `RCS_IDX_OUT) begin
            out_en <= pwdata[`RCS_OUT_EN_BIT];
         end
         if (idx == `RCS_IDX_CLKMODE) begin
            div_sel <= rcs_pkg::rcs_div_t'(pwdata[1:0]);
            dpll_mode <= pwdata[`RCS_MODE_DPLL_BIT];
            mult <= mult_w;
         end
      end
   end

   // Strap sets the source; software may override it later
   always_ff @(posedge clock) begin
      if (!rstn) begin
         crystal_driver_on <= 1'b1;
      end else if (pwdn_n && !strap_done) begin
         crystal_driver_on <= strap_dec[1];
      end else if (wr_en && idx == `RCS_IDX_XTAL && paddr[1:0] == 2'b00) begin
         crystal_driver_on <= pwdata[`RCS_XTAL_ON_BIT];
      end
   end

   // Reference source and period measurement
   assign ref_raw = crystal_driver_on ? crystal_in_pin : lnk.rev_ref;
   assign ref_rise = ref_q & ~ref_q2;
   assign ref_lost = (ph_cnt >= 8'(MISS_CYC));
   assign src_change = (crystal_driver_on != xtal_prev);

   always_ff @(posedge clock) begin
      if (!rstn) begin
         ref_q <= 1'b0;
         ref_q2 <= 1'b0;
         xtal_prev <= 1'b1;
      end else begin
         ref_q <= ref_raw & strap_done;
         ref_q2 <= ref_q;
         xtal_prev <= crystal_driver_on;
      end
   end

   // Period follows every rising reference edge outside RCS_LK_DOWN, so drift and spreading carry over
   always_ff @(posedge clock) begin
      if (!rstn) begin
         ph_cnt <= 8'h00;
         period <= 8'(`RCS_REF_PERIOD_CYC);
      end else if (ref_rise) begin
         ph_cnt <= 8'h00;
         if (lock_state != rcs_pkg::RCS_LK_DOWN) begin
            period <= 8'(ph_cnt + 8'h01);
         end
      end else if (!ref_lost) begin
         ph_cnt <= ph_cnt + 8'h01;
      end
   end

   // Source change or lost reference drops lock; relock is automatic
   always_ff @(posedge clock) begin
      if (!rstn) begin
         lock_state <= rcs_pkg::RCS_LK_DOWN;
         edge_cnt <= 6'h00;
      end else begin
         unique case (lock_state)
            rcs_pkg::RCS_LK_DOWN: begin
               edge_cnt <= 6'h00;
               if (ref_rise && !src_change) begin
                  lock_state <= rcs_pkg::RCS_LK_ACQ;
               end
            end
            rcs_pkg::RCS_LK_ACQ: begin
               if (src_change || ref_lost) begin
                  lock_state <= rcs_pkg::RCS_LK_DOWN;
               end else if (ref_rise) begin
                  if (edge_cnt == 6'(LOCK_EDGES - 1)) begin
                     lock_state <= rcs_pkg::RCS_LK_LOCK;
                  end
                  edge_cnt <= edge_cnt + 6'h01;
               end
            end
            rcs_pkg::RCS_LK_LOCK: begin
               if (src_change || ref_lost) begin
                  lock_state <= rcs_pkg::RCS_LK_DOWN;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         lnk.ref_request <= 1'b0;
         lnk.link_locked <= 1'b0;
         reverse_ref_detected <= 1'b0;
         crystal_in_pin_en <= 1'b0;
         crystal_out_pin_o <= 1'b0;
         crystal_out_pin_oe <= 1'b0;
      end else begin
         lnk.ref_request <= strap_done & ~crystal_driver_on;
         lnk.link_locked <= (lock_state == rcs_pkg::RCS_LK_LOCK);
         reverse_ref_detected <= ~crystal_driver_on &
            (lock_state == rcs_pkg::RCS_LK_LOCK);
         crystal_in_pin_en <= strap_done & crystal_driver_on;
         crystal_out_pin_o <= strap_done & crystal_driver_on & ~crystal_in_pin;
         crystal_out_pin_oe <= strap_done & crystal_driver_on;
      end
   end

   // One accumulator serves both modes: output = reference * step / 128
   always_comb begin
      if (dpll_mode) begin
         step_sel = {mult, 1'b0};
      end else begin
         unique case (div_sel)
            rcs_pkg::RCS_DIV_1: step_sel = 9'h080;
            rcs_pkg::RCS_DIV_2: step_sel = 9'h040;
            rcs_pkg::RCS_DIV_4, rcs_pkg::RCS_DIV_4B: step_sel = 9'h020;
         endcase
      end
   end

   // Held period with a longer threshold models the free-running slowdown
   assign slow = ~crystal_driver_on & (lock_state != rcs_pkg::RCS_LK_LOCK);
   assign thr = 16'(period) * (slow ? `RCS_THR_SLOW : `RCS_THR_LOCKED);
   assign acc_sum = {1'b0, acc} + {8'h00, step_cur};

   always_ff @(posedge clock) begin
      if (!rstn) begin
         acc <= 16'h0000;
         sclk <= 1'b0;
         step_cur <= 9'h080;
      end else if (!out_en) begin
         acc <= 16'h0000;
         sclk <= 1'b0;
         step_cur <= step_sel;
      end else if (acc_sum >= {1'b0, thr}) begin
         sclk <= ~sclk;
         acc <= 16'(acc_sum - {1'b0, thr});
         // New step only at a falling edge keeps both half periods whole
         if (sclk) begin
            step_cur <= step_sel;
         end
      end else begin
         acc <= acc_sum[15:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         multi_func_pin_primary_o <= 1'b0;
         multi_func_pin_primary_oe <= 1'b0;
         multi_func_pin_alternate_o <= 1'b0;
         multi_func_pin_alternate_oe <= 1'b0;
      end else begin
         multi_func_pin_primary_o <= out_en & ~route_alt & sclk;
         multi_func_pin_primary_oe <= out_en & ~route_alt;
         multi_func_pin_alternate_o <= out_en & route_alt & sclk;
         multi_func_pin_alternate_oe <= out_en & route_alt;
      end
   end

endmodule

`default_nettype wire

/* rcs_link_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module rcs_link_properties #(
   parameter int LOCK_EDGES = 32
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Link
   input wire logic rev_ref,
   input wire logic ref_request,
   input wire logic link_locked,
   // Pins
   input wire logic crystal_in_pin_en,
   input wire logic crystal_out_pin_oe,
   input wire logic multi_func_pin_primary_oe,
   input wire logic multi_func_pin_alternate_oe
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   logic ref_d;
   int rises;

   // Rises seen while a reverse lock is pending
   always_ff @(posedge clock) begin
      if (!rstn) begin
         ref_d <= 1'b0;
         rises <= 0;
      end else begin
         ref_d <= rev_ref;
         if (link_locked || !ref_request) begin
            rises <= 0;
         end else if (rev_ref && !ref_d) begin
            rises <= rises + 1;
         end
      end
   end

   // Spreading may stretch a half period by one clock
   sequence s_high;
      rev_ref [*5] ##[1:2] !rev_ref;
   endsequence
   sequence s_low;
      !rev_ref [*5] ##[1:2] rev_ref;
   endsequence

   a_ref_gated: assert property (!ref_request [*2] |-> !rev_ref)
      else $error("reference sent without request");
   a_ref_start: assert property ($rose(ref_request) |-> ##[5:6] rev_ref)
      else $error("reference not started");
   a_half_high: assert property (disable iff (!rstn || !ref_request)
      $rose(rev_ref) |-> s_high) else $error("bad high half period");
   a_half_low: assert property (disable iff (!rstn || !ref_request)
      $fell(rev_ref) |-> s_low) else $error("bad low half period");
   a_lock_drop: assert property ($changed(ref_request)
      |-> ##[0:1] !link_locked) else $error("lock kept over source change");
   a_lock_count: assert property ($rose(link_locked) && ref_request
      |-> rises >= LOCK_EDGES - 1) else $error("reverse lock too early");
   a_lock_time: assert property (disable iff (!rstn || !ref_request)
      $rose(ref_request) |-> ##[300:420] link_locked)
      else $error("reverse lock too late");
   a_xtal_off: assert property (ref_request [*2]
      |-> !crystal_out_pin_oe && !crystal_in_pin_en)
      else $error("crystal pins active in reverse mode");
   a_one_pin: assert property ($onehot0({multi_func_pin_primary_oe,
      multi_func_pin_alternate_oe})) else $error("both clock pins driven");
endmodule

`default_nettype wire

/* reference_clock_source_and_output_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module reference_clock_source_and_output_tb;
   localparam int LOCK = 32;
   logic clock, rstn, pwdn_n, psel, penable, pwrite, xin, ssc;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic pready, pslverr, rerr, xen, xo, xoe, mfp, mfpe, mfa, mfae;
   logic sending, up;
   logic [9:0] strap;
   logic [7:0] dev_addr;
   int fails, check_count, cyc, xc, p, tot;
   // Strap level and expected {invalid, crystal, high address}
   logic [9:0] sv [13] = '{10'h000, 10'h075, 10'h08C, 10'h0A9, 10'h0EC,
      10'h141, 10'h1B8, 10'h230, 10'h2A7, 10'h2C8, 10'h3B6, 10'h33F, 10'h31E};
   logic [2:0] se [13] = '{3'h0, 3'h0, 3'h6, 3'h1, 3'h1, 3'h2, 3'h1, 3'h0,
      3'h3, 3'h3, 3'h6, 3'h2, 3'h2};

   rcs_link_if lnk ();

   rcs_device #(.LOCK_EDGES(LOCK)) i_rcs_device (
      .clock(clock), .rstn(rstn), .pwdn_n(pwdn_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .config_strap_input(strap), .device_address(dev_addr),
      .crystal_in_pin(xin), .crystal_in_pin_en(xen),
      .crystal_out_pin_o(xo), .crystal_out_pin_oe(xoe),
      .multi_func_pin_primary_o(mfp), .multi_func_pin_primary_oe(mfpe),
      .multi_func_pin_alternate_o(mfa), .multi_func_pin_alternate_oe(mfae),
      .lnk(lnk)
   );

   rcs_deser i_rcs_deser (
      .clock(clock), .rstn(rstn), .ssc_enable(ssc),
      .ref_sending(sending), .link_up(up), .lnk(lnk)
   );

   rcs_link_properties #(.LOCK_EDGES(LOCK)) i_rcs_link_properties (
      .clock(clock), .rstn(rstn), .rev_ref(lnk.rev_ref),
      .ref_request(lnk.ref_request), .link_locked(lnk.link_locked),
      .crystal_in_pin_en(xen), .crystal_out_pin_oe(xoe),
      .multi_func_pin_primary_oe(mfpe), .multi_func_pin_alternate_oe(mfae)
   );

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // 25 MHz crystal: five clocks per half period
   always @(posedge clock) begin
      cyc <= cyc + 1;
      xc <= (xc == 4) ? 0 : xc + 1;
      if (xc == 4) begin
         xin <= ~xin;
      end
      if (cyc == 20000) begin
         fails++;
         conclude();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      // Sample mid-cycle, where the answer has settled
      @(negedge clock);
      while (pready !== 1'b1) @(negedge clock);
      rdata = prdata;
      rerr = pslverr;
      @(posedge clock);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rchk(input string nm, input logic [15:0] a,
                       input logic [31:0] m, e);
      apb(1'b0, a, 32'h0);
      chk(nm, rdata & m, e);
   endtask

   // Rise-to-rise period of the selected sensor clock pin
   task automatic period(input logic alt);
      int n, r;
      logic prev, cur;
      n = 0;
      r = 0;
      p = 0;
      @(negedge clock);
      prev = alt ? mfa : mfp;
      while (r < 2 && n < 600) begin
         @(negedge clock);
         cur = alt ? mfa : mfp;
         n++;
         if (r == 1) p++;
         if (cur && !prev) r++;
         prev = cur;
      end
      @(posedge clock);
   endtask

   task automatic wait_lock(input logic lvl);
      int n;
      n = 0;
      @(negedge clock);
      while (lnk.link_locked !== lvl && n < 1000) begin
         @(negedge clock);
         n++;
      end
      chk("lock", lnk.link_locked, lvl);
      @(posedge clock);
   endtask

   task conclude();
      if (fails == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      rstn = 1'b0;
      pwdn_n = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0;
      pwdata = 32'h0;
      xin = 1'b0;
      ssc = 1'b0;
      strap = 10'h31E;
      repeat (4) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      chk("pin oe", {mfpe, mfae}, 32'h0);
      rchk("out", 16'h0018, 32'hFFFFFFFF, 32'h0);
      rchk("cfg", 16'h000C, 32'hFFFFFFFF, 32'h0);
      rchk("xtal", 16'h0010, 32'hFFFFFFFF, 32'h1);
      rchk("mode", 16'h001C, 32'hFFFFFFFF, 32'h4000);
      apb(1'b0, 16'h0100, 32'h0);
      chk("unmapped err", rerr, 32'h1);
      chk("unmapped data", rdata, 32'h0);
      apb(1'b1, 16'h000E, 32'hFFFF);
      chk("unaligned err", rerr, 32'h1);
      rchk("cfg kept", 16'h000C, 32'hFFFFFFFF, 32'h0);
      for (int i = 0; i < 13; i++) begin
         strap <= sv[i];
         pwdn_n <= 1'b0;
         repeat (3) @(posedge clock);
         pwdn_n <= 1'b1;
         repeat (4) @(posedge clock);
         chk("address", dev_addr, se[i][0] ? 8'h84 : 8'h80);
         chk("ref request", lnk.ref_request, !se[i][1]);
         chk("xtal en", xen, se[i][1]);
         rchk("strap flags", 16'h0020, 32'h6, {se[i][2:1], 1'b0});
      end
      strap <= 10'h000;
      repeat (8) @(posedge clock);
      chk("address held", dev_addr, 8'h80);
      chk("source held", lnk.ref_request, 1'b0);
      wait_lock(1'b1);
      apb(1'b1, 16'h0018, 32'h20);
      for (int d = 0; d < 4; d++) begin
         apb(1'b1, 16'h001C, 32'h4000 | d);
         period(1'b0);
         period(1'b0);
         chk("div period", p, 10 << (d == 3 ? 2 : d));
      end
      chk("primary oe", {mfpe, mfae}, 32'h2);
      apb(1'b1, 16'h000C, 32'h4);
      period(1'b1);
      period(1'b1);
      chk("alt period", p, 32'd40);
      chk("alt oe", {mfpe, mfae}, 32'h1);
      apb(1'b1, 16'h000C, 32'h0);
      apb(1'b1, 16'h001C, 32'h8004);
      period(1'b0);
      period(1'b0);
      chk("synth fast", p, 32'd5);
      apb(1'b1, 16'h001C, 32'h2004);
      period(1'b0);
      period(1'b0);
      chk("synth slow", p, 32'd20);
      apb(1'b1, 16'h001C, 32'hFF04);
      rchk("mult max", 16'h001C, 32'hFFFF, 32'hC004);
      apb(1'b1, 16'h001C, 32'h0104);
      rchk("mult min", 16'h001C, 32'hFFFF, 32'h0304);
      apb(1'b1, 16'h001C, 32'h4000);
      apb(1'b1, 16'h0010, 32'h0);
      wait_lock(1'b0);
      wait_lock(1'b1);
      rchk("rev status", 16'h52A8, 32'h20, 32'h20);
      chk("xtal pins", {xen, xoe}, 32'h0);
      chk("link side", {sending, up}, 32'h3);
      period(1'b0);
      period(1'b0);
      chk("rev period", p, 32'd10);
      ssc <= 1'b1;
      tot = 0;
      period(1'b0);
      repeat (8) begin
         period(1'b0);
         tot += p;
      end
      chk("spread", tot > 80 && tot <= 96, 32'h1);
      ssc <= 1'b0;
      apb(1'b1, 16'h0010, 32'h1);
      wait_lock(1'b0);
      wait_lock(1'b1);
      rchk("xtal status", 16'h52A8, 32'h20, 32'h0);
      chk("xtal back", xen, 32'h1);
      conclude();
   end
endmodule

`default_nettype wire
